// >>> design/pcie_port_link_control.sv
// Purpose: Port link control register and its link-side outputs
// Assumes: Config accesses and LTSSM status are synchronous to core_clk
// Notes:   Read data appears one cycle after the read strobe
// Function
// - With extended sync set, L0s exit uses 4096 FTS sets then one SKP set.
// - With extended sync set, L1 exit uses 1024 TS1 sets; the bit is RW, reset 0.
// - Bit 6 is the RW shared reference clock bit, reset 0, 1 meaning common clock.
// - The shared clock bit selects which L0s and L1 exit latencies are reported.
// - Writing one to bit 5 starts link retraining on the port.
// - Bit 5 always reads as zero.
// - Bit 4 is the RW link disable bit, reset 0, 1 disabling the link.
// - Bit 3 is read-only zero, selecting a 64 byte completion boundary.
// - Bits 1:0 are the RW active power management field, reset 00.
// - The power management field is stored and driven out on aspmCtrl; it steers nothing else.
// - Training in progress reads one while a retrain is pending or in Config/Recovery.
`timescale 1ns/100ps

module pcie_port_link_control
   import plc_pkg::*;
#(
   parameter logic [`PLC_CNT_W-1:0] NORM_FTS_CNT  = 13'h0010,
   parameter logic [`PLC_CNT_W-1:0] NORM_TS1_CNT  = 13'h0010,
   parameter logic [2:0]            L0S_LAT_ASYNC = 3'h7,
   parameter logic [2:0]            L0S_LAT_COMMON = 3'h7,
   parameter logic [2:0]            L1_LAT_ASYNC  = 3'h7,
   parameter logic [2:0]            L1_LAT_COMMON = 3'h7
) (
   input  wire logic                       core_clk,
   input  wire logic                       rstn,
   input  wire logic                       cfgWrEn,
   input  wire logic                       cfgRdEn,
   input  wire logic [`PLC_CFG_ADDR_W-1:0] cfgAddr,
   input  wire logic [1:0]                 cfgByteEn,
   input  wire logic [15:0]                cfgWrData,
   output logic      [15:0]                cfgRdData,
   output logic                            cfgRdValid,
   input  wire logic                       ltssmCfgOrRecovery,
   output logic                            retrainReq,
   output logic                            trainingInProgress,
   output logic                            linkOff,
   output logic      [`PLC_CNT_W-1:0]      l0sExitFtsCount,
   output logic                            l0sExitSkpAfterFts,
   output logic      [`PLC_CNT_W-1:0]      l1ExitTs1Count,
   output logic      [2:0]                 l0sExitLatency,
   output logic      [2:0]                 l1ExitLatency,
   output logic      [1:0]                 aspmCtrl
);

   logic      rstnMeta;
   logic      rstnQ;
   plc_ctrl_t ctrl;
   plc_ctrl_t next_ctrl;
   logic      retrainPending;
   logic      next_retrainPending;
   logic [15:0] next_rdData;
   wire       addrHit  = (cfgAddr == `PLC_LNK_CTRL_OFS);
   wire       wrLow    = cfgWrEn && addrHit && cfgByteEn[0];
   wire       retrainWr = wrLow && cfgWrData[`PLC_BIT_RETRAIN];
   wire [15:0] regView;

   // Reset release through two flops
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rstnMeta <= 1'b0;
         rstnQ    <= 1'b0;
      end else begin
         rstnMeta <= 1'b1;
         rstnQ    <= rstnMeta;
      end
   end

   // Write decode of stored fields; high byte is reserved
   // stored fields
   assign next_ctrl.extSync      = wrLow ? cfgWrData[`PLC_BIT_EXT_SYNC]   : ctrl.extSync;
   assign next_ctrl.sharedRefclk = wrLow ? cfgWrData[`PLC_BIT_SHARED_CLK] : ctrl.sharedRefclk;
   assign next_ctrl.linkOff      = wrLow ? cfgWrData[`PLC_BIT_LINK_OFF]   : ctrl.linkOff;
   assign next_ctrl.aspm         = wrLow ?
                                   plc_aspm_t'(cfgWrData[`PLC_ASPM_HI:`PLC_ASPM_LO]) :
                                   ctrl.aspm;

   // pending retrain, set wins over clear
   assign next_retrainPending = retrainWr || (retrainPending && !ltssmCfgOrRecovery);

   // Read view: retrain and boundary bits always zero
   // read-only zeros
   assign regView = {`PLC_RSVD_BYTE,
                     ctrl.extSync,
                     ctrl.sharedRefclk,
                     1'b0,
                     ctrl.linkOff,
                     `PLC_CPL_BOUND_64B,
                     `PLC_RSVD_BIT,
                     ctrl.aspm};
   assign next_rdData = addrHit ? regView : `PLC_ZERO_WORD;

   // Control register state
   always_ff @(posedge core_clk or negedge rstnQ) begin
      if (!rstnQ) begin
         ctrl           <= '{`PLC_RST_BIT, `PLC_RST_BIT, `PLC_RST_BIT, PLC_ASPM_OFF};
         retrainPending <= 1'b0;
      end else begin
         ctrl           <= next_ctrl;
         retrainPending <= next_retrainPending;
      end
   end

   // Read answer one cycle after the strobe
   always_ff @(posedge core_clk or negedge rstnQ) begin
      if (!rstnQ) begin
         cfgRdData  <= `PLC_ZERO_WORD;
         cfgRdValid <= 1'b0;
      end else begin
         cfgRdData  <= cfgRdEn ? next_rdData : cfgRdData;
         cfgRdValid <= cfgRdEn;
      end
   end

   // Link-side outputs from stored fields and the retrain write
   always_ff @(posedge core_clk or negedge rstnQ) begin
      if (!rstnQ) begin
         retrainReq         <= 1'b0;
         linkOff            <= 1'b0;
         l0sExitFtsCount    <= NORM_FTS_CNT;
         l0sExitSkpAfterFts <= 1'b0;
         l1ExitTs1Count     <= NORM_TS1_CNT;
         l0sExitLatency     <= L0S_LAT_ASYNC;
         l1ExitLatency      <= L1_LAT_ASYNC;
         aspmCtrl           <= `PLC_RST_ASPM;
      end else begin
         retrainReq         <= retrainWr;
         linkOff            <= ctrl.linkOff;
         l0sExitFtsCount    <= ctrl.extSync ? `PLC_EXT_FTS_CNT : NORM_FTS_CNT;
         l0sExitSkpAfterFts <= ctrl.extSync;
         l1ExitTs1Count     <= ctrl.extSync ? `PLC_EXT_TS1_CNT : NORM_TS1_CNT;
         l0sExitLatency     <= ctrl.sharedRefclk ? L0S_LAT_COMMON : L0S_LAT_ASYNC;
         l1ExitLatency      <= ctrl.sharedRefclk ? L1_LAT_COMMON : L1_LAT_ASYNC;
         aspmCtrl           <= ctrl.aspm;
      end
   end

   // software wait is not enforced here
   assign trainingInProgress = retrainPending || ltssmCfgOrRecovery;

   // Checks on the register and link outputs
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstnQ);

   property p_ext_fts;
      ctrl.extSync |=> (l0sExitFtsCount == `PLC_EXT_FTS_CNT) && l0sExitSkpAfterFts;
   endproperty
   a_ext_fts: assert property (p_ext_fts) else $error("FTS count wrong");

   property p_ext_ts1;
      !ctrl.extSync |=> (l1ExitTs1Count == NORM_TS1_CNT);
   endproperty
   a_ext_ts1: assert property (p_ext_ts1) else $error("TS1 count wrong");

   property p_ext_ts1_on;
      wrLow && cfgWrData[`PLC_BIT_EXT_SYNC] ##1 ctrl.extSync |=>
         (l1ExitTs1Count == `PLC_EXT_TS1_CNT);
   endproperty
   a_ext_ts1_on: assert property (p_ext_ts1_on) else $error("TS1 ext count wrong");

   property p_cc_store;
      wrLow |=> ctrl.sharedRefclk == $past(cfgWrData[`PLC_BIT_SHARED_CLK]);
   endproperty
   a_cc_store: assert property (p_cc_store) else $error("Shared clock bit lost");

   property p_cc_lat;
      ctrl.sharedRefclk |=> (l0sExitLatency == L0S_LAT_COMMON)
                            && (l1ExitLatency == L1_LAT_COMMON);
   endproperty
   a_cc_lat: assert property (p_cc_lat) else $error("Latency select wrong");

   // A lone retrain write gives exactly one request cycle
   property p_retrain_pulse;
      retrainWr ##1 !retrainWr |-> retrainReq ##1 !retrainReq;
   endproperty
   a_retrain_pulse: assert property (p_retrain_pulse) else $error("Retrain pulse bad");

   property p_retrain_cause;
      retrainReq |-> $past(retrainWr);
   endproperty
   a_retrain_cause: assert property (p_retrain_cause) else $error("Spurious retrain");

   property p_rd_zero;
      cfgRdValid |-> !cfgRdData[`PLC_BIT_RETRAIN] && !cfgRdData[`PLC_BIT_CPL_BOUND];
   endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("RO zero bit set");

   property p_link_off;
      wrLow |=> ##1 linkOff == $past(cfgWrData[`PLC_BIT_LINK_OFF], 2);
   endproperty
   a_link_off: assert property (p_link_off) else $error("Link disable wrong");

   property p_rcb_read;
      cfgRdEn && addrHit |=> cfgRdValid
         && (cfgRdData[`PLC_BIT_CPL_BOUND] == `PLC_CPL_BOUND_64B)
         && (cfgRdData[`PLC_BIT_LINK_OFF] == $past(ctrl.linkOff));
   endproperty
   a_rcb_read: assert property (p_rcb_read) else $error("Read data wrong");

   property p_aspm_store;
      wrLow |=> ##1 aspmCtrl == $past(cfgWrData[`PLC_ASPM_HI:`PLC_ASPM_LO], 2);
   endproperty
   a_aspm_store: assert property (p_aspm_store) else $error("ASPM field lost");

   property p_aspm_quiet;
      wrLow && !cfgWrData[`PLC_BIT_RETRAIN] |=> !retrainReq;
   endproperty
   a_aspm_quiet: assert property (p_aspm_quiet) else $error("ASPM write acted");

   property p_training;
      retrainWr |=> trainingInProgress;
   endproperty
   a_training: assert property (p_training) else $error("Training flag low");

   c_retrain: cover property (retrainWr ##1 retrainReq ##[1:4] ltssmCfgOrRecovery);
   c_ext_sync: cover property (wrLow && cfgWrData[`PLC_BIT_EXT_SYNC] ##2 l0sExitSkpAfterFts);
   c_link_off: cover property ($rose(linkOff) ##[1:20] $fell(linkOff));
   c_read: cover property (cfgRdValid && cfgRdData[`PLC_BIT_SHARED_CLK]);

endmodule

// >>> design/plc_consts.svh
// Purpose: Named constants for the port link control register block
// Assumes: Included by its bare name from the package and the top module
// Notes:   Offsets, field positions, reset values and ordered-set counts
`ifndef PLC_CONSTS_SVH
`define PLC_CONSTS_SVH

// Register location in configuration space
`define PLC_CFG_ADDR_W      12
`define PLC_LNK_CTRL_OFS    12'h07C

// Field positions
`define PLC_BIT_EXT_SYNC    7
`define PLC_BIT_SHARED_CLK  6
`define PLC_BIT_RETRAIN     5
`define PLC_BIT_LINK_OFF    4
`define PLC_BIT_CPL_BOUND   3
`define PLC_ASPM_HI         1
`define PLC_ASPM_LO         0

// Reset and hardwired values
`define PLC_RST_BIT         1'h0
`define PLC_RST_ASPM        2'h0
`define PLC_CPL_BOUND_64B   1'h0
`define PLC_RSVD_BIT        1'h0
`define PLC_RSVD_BYTE       8'h00
`define PLC_ZERO_WORD       16'h0000

// Extended synchronisation ordered-set counts
`define PLC_CNT_W           13
`define PLC_EXT_FTS_CNT     13'h1000
`define PLC_EXT_TS1_CNT     13'h0400

// Software wait after link disable, in microseconds
`define PLC_LINK_OFF_WAIT_US 2000

`endif

// >>> design/plc_pkg.sv
// Purpose: Types shared by the port link control register block
// Assumes: plc_consts.svh supplies the numeric constants
// Notes:   Control fields travel as one packed struct
`include "plc_consts.svh"

package plc_pkg;

   // Active-state power management encodings
   typedef enum logic [1:0] {
      PLC_ASPM_OFF  = 2'h0,
      PLC_ASPM_L0S  = 2'h1,
      PLC_ASPM_RSVD = 2'h2,
      PLC_ASPM_BOTH = 2'h3
   } plc_aspm_t;

   // Stored control fields
   typedef struct packed {
      logic      extSync;
      logic      sharedRefclk;
      logic      linkOff;
      plc_aspm_t aspm;
   } plc_ctrl_t;

endpackage

// >>> verif/plc_link_partner.sv
// Purpose: Link-side partner that answers retrain requests
// Assumes: Requests arrive as one-cycle pulses on core_clk
// Notes:   Waits respDelay+1 cycles, then holds Configuration/Recovery for 4 cycles
`timescale 1ns/100ps

module plc_link_partner (
   input  wire logic       core_clk,
   input  wire logic       rstn,
   input  wire logic       retrainReq,
   input  wire logic [3:0] respDelay,
   output logic            ltssmCfgOrRecovery
);
   logic [4:0] waitCnt;
   logic [2:0] holdCnt;

   // Delay, then a short training burst; requests mid-burst are absorbed
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         waitCnt <= 5'h00;
         holdCnt <= 3'h0;
      end else if (retrainReq && waitCnt == 5'h00 && holdCnt == 3'h0) begin
         waitCnt <= 5'(respDelay) + 5'h01;
      end else if (waitCnt != 5'h00) begin
         waitCnt <= waitCnt - 5'h01;
         if (waitCnt == 5'h01)
            holdCnt <= 3'h4;
      end else if (holdCnt != 3'h0) begin
         holdCnt <= holdCnt - 3'h1;
      end
   end

   assign ltssmCfgOrRecovery = (holdCnt != 3'h0);
endmodule

// >>> verif/tb_pcie_port_link_control.sv
// Purpose: Self-checking bench for the port link control register
// Assumes: Latency parameters set apart so the clock choice is visible
// Notes:   Link disable is undone by reset, never by an early clear
`timescale 1ns/100ps
`include "plc_consts.svh"

module tb_pcie_port_link_control;
   logic core_clk = 1'b0, rstn = 1'b0, cfgWrEn = 1'b0, cfgRdEn = 1'b0;
   logic [11:0] cfgAddr = 12'h000;
   logic [1:0] cfgByteEn = 2'h0, aspmCtrl;
   logic [15:0] cfgWrData = 16'h0000, cfgRdData;
   logic [3:0] respDelay = 4'h0;
   logic cfgRdValid, ltssm, retrainReq, trainingInProgress, linkOff, skp;
   logic [12:0] fts, ts1;
   logic [2:0] l0sLat, l1Lat;
   int n_mismatch = 0, check_count = 0;
   localparam logic [11:0] OFS = `PLC_LNK_CTRL_OFS;

   // Clock at 125 MHz
   always #4 core_clk = ~core_clk;

   pcie_port_link_control #(.L0S_LAT_ASYNC(3'h1), .L0S_LAT_COMMON(3'h2),
      .L1_LAT_ASYNC(3'h3), .L1_LAT_COMMON(3'h4)) pcie_port_link_control_i (
      .core_clk(core_clk), .rstn(rstn), .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn),
      .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData),
      .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid), .ltssmCfgOrRecovery(ltssm),
      .retrainReq(retrainReq), .trainingInProgress(trainingInProgress),
      .linkOff(linkOff), .l0sExitFtsCount(fts), .l0sExitSkpAfterFts(skp),
      .l1ExitTs1Count(ts1), .l0sExitLatency(l0sLat), .l1ExitLatency(l1Lat),
      .aspmCtrl(aspmCtrl));

   plc_link_partner plc_link_partner_i (.core_clk(core_clk), .rstn(rstn),
      .retrainReq(retrainReq), .respDelay(respDelay), .ltssmCfgOrRecovery(ltssm));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop();
      if (n_mismatch == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic rst_seq();
      @(posedge core_clk);
      rstn <= 1'b0;
      repeat (8) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
   endtask

   task automatic wr(input logic [11:0] a, input logic [1:0] be, input logic [15:0] d);
      @(posedge core_clk);
      cfgWrEn <= 1'b1;
      cfgAddr <= a;
      cfgByteEn <= be;
      cfgWrData <= d;
      @(posedge core_clk);
      cfgWrEn <= 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
   endtask

   task automatic rd(input logic [11:0] a, input logic [15:0] exp);
      @(posedge core_clk);
      cfgRdEn <= 1'b1;
      cfgAddr <= a;
      @(posedge core_clk);
      cfgRdEn <= 1'b0;
      #1;
      chk(cfgRdValid, 1'b1);
      chk(cfgRdData, exp);
      @(posedge core_clk);
      #1;
      chk(cfgRdValid, 1'b0);
   endtask

   // Link-side outputs against expected levels
   task automatic outs(input logic [12:0] f, t, input logic [2:0] a, b,
                       input logic s, o, input logic [1:0] m);
      chk({3'h0, fts, 3'h0, ts1}, {3'h0, f, 3'h0, t});
      chk({l0sLat, l1Lat, skp, linkOff, aspmCtrl}, {a, b, s, o, m});
   endtask

   // back-to-back retrain writes, prompt and slow partner
   task automatic t_retrain();
      int k;
      for (int d = 0; d < 7; d += 6) begin
         respDelay <= 4'(d);
         @(posedge core_clk);
         cfgWrEn <= 1'b1;
         cfgAddr <= OFS;
         cfgByteEn <= 2'h1;
         cfgWrData <= 16'h0020;
         @(posedge core_clk);
         #1;
         chk({retrainReq, trainingInProgress}, 2'h3);
         @(posedge core_clk);
         cfgWrEn <= 1'b0;
         #1;
         chk(retrainReq, 1'b1);
         @(posedge core_clk);
         #1;
         chk({retrainReq, trainingInProgress}, 2'h1);
         for (k = 0; k < 20 && ltssm !== 1'b1; k++) begin
            @(posedge core_clk);
            #1;
            chk(trainingInProgress, 1'b1);
         end
         if (k == 20) begin
            chk(ltssm, 1'b1);
            report_and_stop();
         end
         for (k = 0; k < 20 && ltssm !== 1'b0; k++) begin
            @(posedge core_clk);
            #1;
         end
         if (k == 20) begin
            chk(ltssm, 1'b0);
            report_and_stop();
         end
         @(posedge core_clk);
         #1;
         chk(trainingInProgress, 1'b0);
         rd(OFS, 16'h0000);
      end
   endtask

   // reset values on outputs and register
   task automatic t_reset_vals();
      outs(13'h10, 13'h10, 3'h1, 3'h3, 1'b0, 1'b0, 2'h0);
      rd(OFS, 16'h0000);
   endtask

   task automatic t_ext_sync();
      wr(OFS, 2'h1, 16'h0080);
      outs(13'h1000, 13'h0400, 3'h1, 3'h3, 1'b1, 1'b0, 2'h0);
      rd(OFS, 16'h0080);
   endtask

   task automatic t_shared_clk();
      wr(OFS, 2'h1, 16'h0040);
      outs(13'h10, 13'h10, 3'h2, 3'h4, 1'b0, 1'b0, 2'h0);
      rd(OFS, 16'h0040);
      wr(OFS, 2'h1, 16'h0000);
      outs(13'h10, 13'h10, 3'h1, 3'h3, 1'b0, 1'b0, 2'h0);
   endtask

   task automatic t_aspm();
      for (int i = 0; i < 4; i++) begin
         wr(OFS, 2'h1, 16'(i));
         outs(13'h10, 13'h10, 3'h1, 3'h3, 1'b0, 1'b0, 2'(i));
         rd(OFS, 16'(i));
      end
   endtask

   task automatic t_refused();
      wr(OFS, 2'h2, 16'h0090);
      wr(12'h078, 2'h1, 16'h0090);
      rd(OFS, 16'h0003);
      rd(12'h078, 16'h0000);
   endtask

   task automatic t_link_off();
      wr(OFS, 2'h3, 16'hFFFF);
      rd(OFS, 16'h00D3);
      chk(linkOff, 1'b1);
      rst_seq();
      outs(13'h10, 13'h10, 3'h1, 3'h3, 1'b0, 1'b0, 2'h0);
   endtask

   initial begin
      rst_seq();
      t_reset_vals();
      t_ext_sync();
      t_shared_clk();
      t_retrain();
      t_aspm();
      t_refused();
      t_link_off();
      report_and_stop();
   end
endmodule
